// >>> design/sps_defs.svh
// width, fifo depth and reset values of the shift and store block
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
`define SPS_WIDTH 8
`define SPS_FIFO_DEPTH 16
`define SPS_SHIFT_RST 8'h00
`define SPS_STORE_RST 8'h00
`endif

// >>> design/sps_pkg.sv
// types shared by the shift and store block
package sps_pkg;
  typedef logic [7:0] sps_byte_t;
  typedef enum logic {
    SPS_TRISTATE,
    SPS_OPEN_DRAIN
  } sps_variant_e;
endpackage : sps_pkg

// >>> design/sps_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module sps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
    logic [WIDTH-1:0] dout;
    logic dvalid;
  } sps_fifo_s;
  sps_fifo_s st_q, st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic full, empty, push, pop;

  // occupancy flags and handshakes
  assign full = (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]) && (st_q.wr[AW] != st_q.rd[AW]);
  assign empty = (st_q.wr == st_q.rd);
  assign in_ready = !full;
  assign push = in_valid && !full;
  assign pop = !empty && (!st_q.dvalid || out_ready);
  assign out_valid = st_q.dvalid;
  assign out_data = st_q.dout;

  // pointer and output register update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = st_q.wr + 1'b1;
    end
    if (out_ready && st_q.dvalid) begin
      st_d.dvalid = 1'b0;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
      st_d.dout = mem_q[st_q.rd[AW-1:0]];
      st_d.dvalid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[st_q.wr[AW-1:0]] <= in_data;
    end
  end
endmodule : sps_fifo

// >>> design/sps_shift_store.sv
// eight-bit serial-in parallel-out shift register with storage register
// Operation
// - eight-stage shift register feeds an eight-bit storage register.
// - shift and store each have their own clock input.
// - both act on rising edges only; levels and falling edges hold.
// - common clocks: storage takes pre-edge shift contents, one shift behind.
// - low clear zeroes shift stages at once; storage untouched.
// - rising shift edge: first stage takes serial input, others shift along.
// - no shift edge and clear high: stages hold.
// - rising store edge copies all eight stages in parallel.
// - no store edge: storage holds whatever else happens.
// - outputs driven while enable low (open-drain: only bits storing zero), released while high.
// - last stage appears on serial output for cascading.
// - parallel outputs three-state or open-drain, same register behaviour.
`timescale 1ns/1ps
`include "sps_defs.svh"
module sps_shift_store #(
  parameter int WIDTH = `SPS_WIDTH,
  parameter int FIFO_DEPTH = `SPS_FIFO_DEPTH,
  parameter sps_pkg::sps_variant_e VARIANT = sps_pkg::SPS_TRISTATE
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial side
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic shift_clear_n,
  output logic serial_out,
  // storage side
  input wire logic store_clk,
  input wire logic output_enable_n,
  // parallel pins
  output logic [WIDTH-1:0] parallel_out,
  output logic [WIDTH-1:0] parallel_oe,
  // stored word stream
  output logic word_valid,
  input wire logic word_ready,
  output logic [WIDTH-1:0] word_data,
  output logic word_overflow
);
  typedef struct packed {
    logic shift_clk_prev;
    logic store_clk_prev;
    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] store_reg;
    logic overflow;
  } sps_state_s;
  sps_state_s st_q, st_d;
  logic shift_rise, store_rise, fifo_ready;
  logic [WIDTH-1:0] shift_now;

  // edge detection on the sampled clock pins
  assign shift_rise = shift_clk && !st_q.shift_clk_prev;
  assign store_rise = store_clk && !st_q.store_clk_prev;
  // clear overrides the registered stages combinationally
  assign shift_now = shift_clear_n ? st_q.shift_reg : '0;

  // next-state logic
  always_comb begin
    st_d = st_q;
    st_d.shift_clk_prev = shift_clk;
    st_d.store_clk_prev = store_clk;
    if (!shift_clear_n) begin
      st_d.shift_reg = '0;
    end else if (shift_rise) begin
      st_d.shift_reg = {st_q.shift_reg[WIDTH-2:0], serial_in};
    end // else hold
    if (store_rise) begin
      st_d.store_reg = shift_now; // pre-edge contents
    end // else hold
    if (store_rise && !fifo_ready) begin
      st_d.overflow = 1'b1; // sticky, cleared only by reset
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= {1'b0, 1'b0, `SPS_SHIFT_RST, `SPS_STORE_RST, 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // cascade output straight from the last stage
  assign serial_out = shift_now[WIDTH-1];

  // pin drivers for both output variants
  always_comb begin
    if (VARIANT == sps_pkg::SPS_OPEN_DRAIN) begin
      parallel_out = '0;
      parallel_oe = output_enable_n ? '0 : ~st_q.store_reg;
    end else begin
      parallel_out = st_q.store_reg;
      parallel_oe = output_enable_n ? '0 : '1;
    end
  end
  assign word_overflow = st_q.overflow;

  // each stored word is queued for the consumer while the fifo has room
  sps_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(store_rise),
    .in_ready(fifo_ready),
    .in_data(shift_now),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

  // store follows shift by one edge when clocks are tied
  tied_lag_a: assert property (@(posedge ref_clk) disable iff (rst)
    store_rise |=> st_q.store_reg == $past(shift_now))
    else $error("storage did not take pre-edge shift contents");
  clear_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    !shift_clear_n |-> serial_out == 1'b0 ##1 st_q.shift_reg == '0)
    else $error("clear did not zero shift stages");
  shift_move_a: assert property (@(posedge ref_clk) disable iff (rst)
    shift_clear_n && shift_rise |=> st_q.shift_reg ==
      {$past(st_q.shift_reg[WIDTH-2:0]), $past(serial_in)})
    else $error("shift edge did not move stages");
  shift_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    shift_clear_n && !shift_rise |=> $stable(st_q.shift_reg))
    else $error("shift stages changed without edge");
  store_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !store_rise |=> $stable(st_q.store_reg))
    else $error("storage changed without edge");
  level_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    shift_clk && $past(shift_clk) && shift_clear_n |=> $stable(st_q.shift_reg))
    else $error("high shift clock level moved stages");
  out_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
    output_enable_n |-> parallel_oe == '0)
    else $error("outputs driven while disabled");
  cascade_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    shift_clear_n && shift_rise ##1 shift_clear_n |->
      serial_out == $past(st_q.shift_reg[WIDTH-2]))
    else $error("serial output not last stage");
endmodule : sps_shift_store

// >>> testbench/sps_ctrl_model.sv
// controller model driving the shift, store, clear and enable pins
`timescale 1ns/1ps
module sps_ctrl_model (
  // clock
  input wire logic ref_clk,
  // pins toward the device
  output logic serial_in,
  output logic shift_clk,
  output logic shift_clear_n,
  output logic store_clk,
  output logic output_enable_n
);
  // idle levels from time zero
  initial begin
    serial_in = 1'b0;
    shift_clk = 1'b0;
    shift_clear_n = 1'b1;
    store_clk = 1'b0;
    output_enable_n = 1'b0;
  end
  // one clock pulse; data dropped to its inverse once its hold is over
  task pulse(input logic sh, input logic st, input logic b);
    @(negedge ref_clk);
    serial_in = b;
    shift_clk = sh;
    store_clk = st;
    @(negedge ref_clk);
    shift_clk = 1'b0;
    store_clk = 1'b0;
    serial_in = ~b;
  endtask : pulse
  // static levels of clear and enable
  task set_pins(input logic clr_n, input logic oe_n);
    @(negedge ref_clk);
    shift_clear_n = clr_n;
    output_enable_n = oe_n;
  endtask : set_pins
endmodule : sps_ctrl_model

// >>> testbench/sps_shift_store_tb_top.sv
// self-checking bench for the shift and store block
`timescale 1ns/1ps
module sps_shift_store_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic word_ready = 1'b0;
  logic serial_in, shift_clk, shift_clear_n, store_clk, output_enable_n;
  logic serial_out, word_valid, word_overflow;
  logic [7:0] parallel_out, parallel_oe, word_data;
  logic [7:0] od_out, od_oe;
  int n_fail = 0;
  int cmp_count = 0;
  int nw = 0;
  typedef struct {logic [7:0] d; logic oe_n; logic [7:0] oe;} sps_row_s;
  sps_row_s rows [4] = '{'{8'ha5, 1'b0, 8'hff}, '{8'h00, 1'b1, 8'h00},
                         '{8'hff, 1'b0, 8'hff}, '{8'h3c, 1'b1, 8'h00}};
  sps_ctrl_model ctrl (.ref_clk(ref_clk), .serial_in(serial_in), .shift_clk(shift_clk),
    .shift_clear_n(shift_clear_n), .store_clk(store_clk), .output_enable_n(output_enable_n));
  sps_shift_store dut (.ref_clk(ref_clk), .rst(rst), .serial_in(serial_in),
    .shift_clk(shift_clk), .shift_clear_n(shift_clear_n), .serial_out(serial_out),
    .store_clk(store_clk), .output_enable_n(output_enable_n), .parallel_out(parallel_out),
    .parallel_oe(parallel_oe), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .word_overflow(word_overflow));
  // open-drain variant on the same pins
  sps_shift_store #(.VARIANT(sps_pkg::SPS_OPEN_DRAIN)) dut_od (.ref_clk(ref_clk), .rst(rst),
    .serial_in(serial_in), .shift_clk(shift_clk), .shift_clear_n(shift_clear_n),
    .serial_out(), .store_clk(store_clk), .output_enable_n(output_enable_n),
    .parallel_out(od_out), .parallel_oe(od_oe), .word_valid(), .word_ready(1'b1),
    .word_data(), .word_overflow());
  // 50 ns clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // compare one value
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // shift a byte in, first bit ending in the last stage
  task shift_byte(input logic [7:0] d, input logic tied);
    for (int i = 7; i >= 0; i--) ctrl.pulse(1'b1, tied, d[i]);
  endtask : shift_byte
  // counts and verdict
  task wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // hang guard
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    chk("reset out", 8'h00, parallel_out);
    foreach (rows[k]) begin
      ctrl.set_pins(1'b1, rows[k].oe_n);
      shift_byte(rows[k].d, 1'b0);
      ctrl.pulse(1'b0, 1'b1, 1'b0);
      chk("parallel", rows[k].d, parallel_out);
      chk("oe", rows[k].oe, parallel_oe);
      chk("od out", 8'h00, od_out);
      chk("od oe", rows[k].oe_n ? 8'h00 : ~rows[k].d, od_oe);
      chk("serial out", {7'h00, rows[k].d[7]}, {7'h00, serial_out});
    end
    ctrl.set_pins(1'b0, 1'b1);
    ctrl.pulse(1'b1, 1'b0, 1'b1);
    chk("clear serial", 8'h00, {7'h00, serial_out});
    chk("clear hold", 8'h3c, parallel_out);
    ctrl.set_pins(1'b1, 1'b0);
    ctrl.pulse(1'b0, 1'b1, 1'b1);
    chk("cleared", 8'h00, parallel_out);
    shift_byte(8'h81, 1'b1);
    chk("tied", 8'h40, parallel_out);
    repeat (6) ctrl.pulse(1'b0, 1'b1, 1'b0);
    chk("overflow", 8'h01, {7'h00, word_overflow});
    chk("head", 8'ha5, word_data);
    word_ready = 1'b1;
    repeat (30) begin
      nw += int'(word_valid === 1'b1);
      @(negedge ref_clk);
    end
    chk("drained", 8'd17, nw[7:0]);
    wrap_up();
  end
endmodule : sps_shift_store_tb_top
